//--- bmc_consts.svh
`ifndef BMC_CONSTS_SVH
`define BMC_CONSTS_SVH

// Configuration space dword offsets
`define BMC_OFS_MISC      8'h64
`define BMC_OFS_CLK       8'h68

// Event mask byte, bits 7:0 of the dword at 0x64
`define BMC_MASK_RD_A     1
`define BMC_MASK_DW_A     2
`define BMC_MASK_TABORT   3
`define BMC_MASK_MABORT   4
`define BMC_MASK_DW_B     5
`define BMC_MASK_RD_B     6
`define BMC_MASK_USED     8'h7E
`define BMC_MASK_RST      8'h00

// General purpose fields, low bit of each 4-bit field
`define BMC_GP_CLR_LSB    8
`define BMC_GP_SET_LSB    12
`define BMC_GP_OECLR_LSB  16
`define BMC_GP_OESET_LSB  20
`define BMC_GP_RST        4'h0

// Secondary clock control
`define BMC_CLK_PAIRS     4
`define BMC_CLK_USED      14
`define BMC_CLK_RST       14'h0000

`endif

//--- bmc_pkg.sv
package bmc_pkg;

   // Events that may raise the primary system error output
   typedef enum {
      BMC_EVT_RD_NODATA,
      BMC_EVT_DW_NODELIVER,
      BMC_EVT_TABORT_PW,
      BMC_EVT_MABORT_PW,
      BMC_EVT_COUNT
   } bmc_evt_e;

   typedef logic [3:0] bmc_evt_t;
   typedef logic [7:0] bmc_mask_t;

endpackage

//--- bmc_serr_if.sv
`timescale 1ns/1ns
interface bmc_serr_if;
   bmc_pkg::bmc_evt_t  evt;
   bmc_pkg::bmc_mask_t mask;
   logic               cmd_en;
   logic               raise;

   modport regs (output evt, output mask, output cmd_en, input raise);
   modport gate (input evt, input mask, input cmd_en, output raise);
endinterface

//--- bmc_pin_sync.sv
`timescale 1ns/1ns
module bmc_pin_sync #(
   parameter int W = 4
) (
   input  wire logic         sys_clk_i,
   input  wire logic         sys_rst_i,
   input  wire logic [W-1:0] pin_i,
   output logic      [W-1:0] level_o
);
   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;
   wire  [W-1:0] settled = ~(s2 ^ s3);
   wire  [W-1:0] next_level = (s3 & settled) | (level_o & ~settled);

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         s1      <= '0;
         s2      <= '0;
         s3      <= '0;
         level_o <= '0;
      end else begin
         s1      <= pin_i;
         s2      <= s1;
         s3      <= s2;
         level_o <= next_level;
      end
   end
endmodule

//--- bmc_serr_gate.sv
`timescale 1ns/1ns
`include "bmc_consts.svh"
module bmc_serr_gate (
   bmc_serr_if.gate serr
);
   // Two mask bits share each retry-exhaustion event; either one silences it
   wire rd_ok = serr.evt[bmc_pkg::BMC_EVT_RD_NODATA]
              & ~serr.mask[`BMC_MASK_RD_A]
              & ~serr.mask[`BMC_MASK_RD_B];
   wire dw_ok = serr.evt[bmc_pkg::BMC_EVT_DW_NODELIVER]
              & ~serr.mask[`BMC_MASK_DW_A]
              & ~serr.mask[`BMC_MASK_DW_B];
   wire ta_ok = serr.evt[bmc_pkg::BMC_EVT_TABORT_PW]
              & ~serr.mask[`BMC_MASK_TABORT];
   wire ma_ok = serr.evt[bmc_pkg::BMC_EVT_MABORT_PW]
              & ~serr.mask[`BMC_MASK_MABORT];

   assign serr.raise = serr.cmd_en & (rd_ok | dw_ok | ta_ok | ma_ok);
endmodule

//--- bmc_config_regs.sv
// What this block does
// - Event mask bits 0,7 reserved, read zero
// - Clear mask bit lets event assert error
// - Mask bits 1 and 6 gate read-nodata
// - Mask bits 2 and 5 gate write-nodelivery
// - Mask bit 3 gates posted target abort
// - Mask bit 4 gates posted master abort
// - Clear-field one drives enabled pin low
// - Set-field one drives enabled pin high
// - Pin changes cycle after write completes
// - Input-only pins never driven
// - Zero writes ignored, fields read all ones since reset
// - Enable-clear one makes pin input only
// - Enable-set one drives stored data out
// - Clocks 0-3 off only when both set
// - Clocks 4-9 single disable bit, low
// - Clock control bits 15:14 read 00
`timescale 1ns/1ns
`include "bmc_consts.svh"
module bmc_config_regs #(
   parameter int GPIO_W = 4,
   parameter int CLK_N  = 10
) (
   input  wire logic                sys_clk_i,
   input  wire logic                sys_rst_i,
   // Configuration access from the primary bus target
   input  wire logic                cfg_wr_i,
   input  wire logic                cfg_rd_i,
   input  wire logic [7:0]          cfg_addr_i,
   input  wire logic [3:0]          cfg_be_i,
   input  wire logic [31:0]         cfg_wdata_i,
   output logic      [31:0]         cfg_rdata_o,
   output logic                     cfg_ack_o,
   // Error events and command register enable
   input  wire logic                evt_rd_nodata_i,
   input  wire logic                evt_dw_nodeliver_i,
   input  wire logic                evt_tabort_pw_i,
   input  wire logic                evt_mabort_pw_i,
   input  wire logic                serr_cmd_en_i,
   output logic                     primary_system_error_out_n_o,
   output logic                     primary_system_error_oe_o,
   // General purpose pins
   input  wire logic [GPIO_W-1:0]   gpio_i,
   output logic      [GPIO_W-1:0]   gpio_o,
   output logic      [GPIO_W-1:0]   gpio_oe_o,
   output logic      [GPIO_W-1:0]   gpio_level_o,
   // Secondary clock output enables, low holds the clock low
   output logic      [CLK_N-1:0]    secondary_clock_outputs_en_o
);

   ////////////////////////////////////////////////////////////////////////
   // Elaboration checks

   if (GPIO_W != 4) begin : g_bad_gpio
      $error("GPIO_W must be 4 to fit the packed fields");
   end
   if (CLK_N != 10) begin : g_bad_clk
      $error("CLK_N must be 10 to fit the clock control field");
   end

   ////////////////////////////////////////////////////////////////////////
   // Access decode

   wire hit_misc = cfg_addr_i == `BMC_OFS_MISC;
   wire hit_clk  = cfg_addr_i == `BMC_OFS_CLK;
   wire wr_misc  = cfg_wr_i & hit_misc;
   wire wr_clk   = cfg_wr_i & hit_clk;

   ////////////////////////////////////////////////////////////////////////
   // Event mask byte

   bmc_pkg::bmc_mask_t mask;
   wire bmc_pkg::bmc_mask_t next_mask =
      cfg_wdata_i[7:0] & `BMC_MASK_USED;

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         mask <= `BMC_MASK_RST;
      end else if (wr_misc && cfg_be_i[0]) begin
         mask <= next_mask;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // System error gating, open-drain output

   bmc_serr_if serr ();
   assign serr.evt    = {evt_mabort_pw_i, evt_tabort_pw_i,
                         evt_dw_nodeliver_i, evt_rd_nodata_i};
   assign serr.mask   = mask;
   assign serr.cmd_en = serr_cmd_en_i;

   bmc_serr_gate u_gate (
      .serr (serr)
   );

   logic serr_drive;
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         serr_drive <= 1'b0;
      end else begin
         serr_drive <= serr.raise;
      end
   end
   // Open drain: only ever pulls low
   assign primary_system_error_out_n_o = 1'b0;
   assign primary_system_error_oe_o    = serr_drive;

   ////////////////////////////////////////////////////////////////////////
   // General purpose fields and pin state

   logic [GPIO_W-1:0] f_clr;
   logic [GPIO_W-1:0] f_set;
   logic [GPIO_W-1:0] f_oeclr;
   logic [GPIO_W-1:0] f_oeset;
   logic [GPIO_W-1:0] out_data;
   logic [GPIO_W-1:0] out_en;

   wire wr_b1 = wr_misc & cfg_be_i[1];
   wire wr_b2 = wr_misc & cfg_be_i[2];
   wire [GPIO_W-1:0] w_clr   = cfg_wdata_i[`BMC_GP_CLR_LSB +: GPIO_W];
   wire [GPIO_W-1:0] w_set   = cfg_wdata_i[`BMC_GP_SET_LSB +: GPIO_W];
   wire [GPIO_W-1:0] w_oeclr = cfg_wdata_i[`BMC_GP_OECLR_LSB +: GPIO_W];
   wire [GPIO_W-1:0] w_oeset = cfg_wdata_i[`BMC_GP_OESET_LSB +: GPIO_W];

   // Zero bits leave a field alone; it keeps showing every one written since reset
   wire [GPIO_W-1:0] next_clr   = f_clr   | w_clr;
   wire [GPIO_W-1:0] next_set   = f_set   | w_set;
   wire [GPIO_W-1:0] next_oeclr = f_oeclr | w_oeclr;
   wire [GPIO_W-1:0] next_oeset = f_oeset | w_oeset;
   // Set wins when one write both sets and clears a bit
   wire [GPIO_W-1:0] next_data = (out_data & ~w_clr) | w_set;
   wire [GPIO_W-1:0] next_en   = (out_en & ~w_oeclr) | w_oeset;

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         f_clr <= `BMC_GP_RST;
         f_set <= `BMC_GP_RST;
      end else if (wr_b1) begin
         f_clr <= next_clr;
         f_set <= next_set;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         f_oeclr <= `BMC_GP_RST;
         f_oeset <= `BMC_GP_RST;
      end else if (wr_b2) begin
         f_oeclr <= next_oeclr;
         f_oeset <= next_oeset;
      end
   end

   // Per-pin stored level and driver enable
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         out_data <= `BMC_GP_RST;
         out_en   <= `BMC_GP_RST;
      end else begin
         if (wr_b1) begin
            out_data <= next_data;
         end
         if (wr_b2) begin
            out_en <= next_en;
         end
      end
   end

   // Data is held while the driver is off, so a later enable drives it
   assign gpio_o    = out_data;
   assign gpio_oe_o = out_en;

   bmc_pin_sync #(
      .W (GPIO_W)
   ) u_gpio_sync (
      .sys_clk_i (sys_clk_i),
      .sys_rst_i (sys_rst_i),
      .pin_i     (gpio_i),
      .level_o   (gpio_level_o)
   );

   ////////////////////////////////////////////////////////////////////////
   // Secondary clock control

   logic [`BMC_CLK_USED-1:0] clk_ctl;
   wire  [`BMC_CLK_USED-1:0] next_clk_ctl = {
      cfg_be_i[1] ? cfg_wdata_i[13:8] : clk_ctl[13:8],
      cfg_be_i[0] ? cfg_wdata_i[7:0]  : clk_ctl[7:0]
   };

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         clk_ctl <= `BMC_CLK_RST;
      end else if (wr_clk) begin
         clk_ctl <= next_clk_ctl;
      end
   end

   wire [CLK_N-1:0] clk_en;
   for (genvar i = 0; i < CLK_N; i++) begin : g_clk
      if (i < `BMC_CLK_PAIRS) begin : g_pair
         assign clk_en[i] = ~&clk_ctl[2*i +: 2];
      end else begin : g_single
         assign clk_en[i] = ~clk_ctl[`BMC_CLK_PAIRS + i];
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         secondary_clock_outputs_en_o <= {CLK_N{1'b1}};
      end else begin
         secondary_clock_outputs_en_o <= clk_en;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read data, answered one cycle after the request

   wire [31:0] rd_misc = {8'h00, f_oeset, f_oeclr, f_set, f_clr,
                          mask & `BMC_MASK_USED};
   wire [31:0] rd_clk  = {16'h0000, 2'b00, clk_ctl};
   wire [31:0] rd_mux  = hit_misc ? rd_misc :
                         hit_clk  ? rd_clk  : 32'h0000_0000;

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         cfg_rdata_o <= 32'h0000_0000;
         cfg_ack_o   <= 1'b0;
      end else begin
         cfg_rdata_o <= cfg_rd_i ? rd_mux : 32'h0000_0000;
         cfg_ack_o   <= cfg_rd_i | cfg_wr_i;
      end
   end

endmodule

//--- bmc_config_regs_checker.sv
`timescale 1ns/1ns
module bmc_config_regs_checker #(
   parameter int GPIO_W = 4,
   parameter int CLK_N  = 10
) (
   input wire logic              sys_clk_i,
   input wire logic              sys_rst_i,
   input wire logic              cfg_wr_i,
   input wire logic              cfg_rd_i,
   input wire logic [7:0]        cfg_addr_i,
   input wire logic [3:0]        cfg_be_i,
   input wire logic [31:0]       cfg_wdata_i,
   input wire logic [31:0]       cfg_rdata_o,
   input wire logic              cfg_ack_o,
   input wire logic              evt_rd_nodata_i,
   input wire logic              evt_dw_nodeliver_i,
   input wire logic              evt_tabort_pw_i,
   input wire logic              evt_mabort_pw_i,
   input wire logic              serr_cmd_en_i,
   input wire logic              primary_system_error_oe_o,
   input wire logic [GPIO_W-1:0] gpio_o,
   input wire logic [GPIO_W-1:0] gpio_oe_o,
   input wire logic [CLK_N-1:0]  secondary_clock_outputs_en_o
);
   wire logic [3:0] ev = {evt_rd_nodata_i, evt_dw_nodeliver_i,
                          evt_tabort_pw_i, evt_mabort_pw_i};
   wire logic [3:0] st = cfg_wdata_i[15:12];
   wire logic [3:0] oes = cfg_wdata_i[23:20];
   logic      [CLK_N-1:0] exp_en;
   // Pairs for clocks 0-3, single bits above
   always_comb begin
      for (int i = 0; i < CLK_N; i++) begin
         exp_en[i] = (i < 4) ? !(cfg_wdata_i[2*i] && cfg_wdata_i[2*i+1])
                             : !cfg_wdata_i[i+4];
      end
   end
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);
   sequence s_rd(a); cfg_rd_i && cfg_addr_i == a; endsequence
   sequence s_wr(b);
      cfg_wr_i && cfg_addr_i == 8'h64 && cfg_be_i[b];
   endsequence
   sequence s_clk_wr; cfg_wr_i && cfg_addr_i == 8'h68 && cfg_be_i[1:0] == 2'h3;
   endsequence
   property p_ack; (cfg_wr_i || cfg_rd_i) |=> cfg_ack_o; endproperty
   a_ack: assert property (p_ack) else $error("access not acked");
   property p_mask_rsv;
      s_rd(8'h64) |=> cfg_rdata_o[7] == 1'b0 && !cfg_rdata_o[0];
   endproperty
   a_mask_rsv: assert property (p_mask_rsv) else $error("mask bit");
   property p_clk_rsv; s_rd(8'h68) |=> cfg_rdata_o[15:14] == 2'h0; endproperty
   a_clk_rsv: assert property (p_clk_rsv) else $error("clock top");
   property primary_system_error_pin_off;
      !serr_cmd_en_i |=> !primary_system_error_oe_o;
   endproperty
   a_serr_off: assert property (primary_system_error_pin_off) else $error("error on");
   property primary_system_error_pin_why; primary_system_error_oe_o |-> $past(|ev); endproperty
   a_serr_why: assert property (primary_system_error_pin_why) else $error("no event");
   property p_set; s_wr(1) |=> (gpio_o & $past(st)) == $past(st); endproperty
   a_set: assert property (p_set) else $error("set lost");
   property p_clr;
      s_wr(1) |=> (gpio_o & $past(cfg_wdata_i[11:8] & ~st)) == 4'h0;
   endproperty
   a_clr: assert property (p_clr) else $error("clear lost");
   property p_oe_set; s_wr(2) |=> (gpio_oe_o & $past(oes)) == $past(oes);
   endproperty
   a_oe_set: assert property (p_oe_set) else $error("enable lost");
   property p_oe_clr;
      s_wr(2) |=> (gpio_oe_o & $past(cfg_wdata_i[19:16] & ~oes)) == 4'h0;
   endproperty
   a_oe_clr: assert property (p_oe_clr) else $error("disable lost");
   property p_clk;
      s_clk_wr ##1 !cfg_wr_i |=>
         secondary_clock_outputs_en_o == $past(exp_en, 2);
   endproperty
   a_clk: assert property (p_clk) else $error("clock enable");
endmodule

//--- bmc_cfg_host.sv
`timescale 1ns/1ns
module bmc_cfg_host (
   input  wire logic        sys_clk_i,
   input  wire logic        cfg_ack_i,
   input  wire logic [31:0] cfg_rdata_i,
   output logic             cfg_wr_o = 1'b0,
   output logic             cfg_rd_o = 1'b0,
   output logic      [7:0]  cfg_addr_o = 8'h00,
   output logic      [3:0]  cfg_be_o = 4'h0,
   output logic      [31:0] cfg_wdata_o = 32'h0
);
   task automatic acc(input logic w, input logic [7:0] a, input logic [3:0] be,
                      input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge sys_clk_i);
      cfg_wr_o <= w;
      cfg_rd_o <= !w;
      cfg_addr_o <= a;
      cfg_be_o <= be;
      cfg_wdata_o <= d;
      @(posedge sys_clk_i);
      cfg_wr_o <= 1'b0;
      cfg_rd_o <= 1'b0;
      // Released address and data lines must not keep the old value; byte enables do
      cfg_addr_o <= ~a;
      cfg_wdata_o <= ~d;
      n = 0;
      while (cfg_ack_i !== 1'b1 && n < 8) begin
         @(posedge sys_clk_i);
         n++;
      end
      // A missing, early or late answer spoils the read data
      q = (n == 1) ? cfg_rdata_i : 32'hXXXX_XXXX;
   endtask
endmodule

//--- tb_bmc_config_regs.sv
`timescale 1ns/1ns
module tb_bmc_config_regs;
   logic sys_clk_i = 1'b0, sys_rst_i = 1'b1, serr_cmd_en_i = 1'b1;
   logic cfg_wr_i, cfg_rd_i, cfg_ack_o;
   logic primary_system_error_out_n_o, primary_system_error_oe_o;
   logic [7:0] cfg_addr_i;
   logic [3:0] cfg_be_i, gpio_o, gpio_oe_o, gpio_level_o, evt = 4'h0;
   logic [31:0] cfg_wdata_i, cfg_rdata_o, q;
   logic [9:0] secondary_clock_outputs_en_o, e;
   wire logic [3:0] gpio_i = (gpio_oe_o & gpio_o) | (~gpio_oe_o & 4'hA);
   int error_cnt = 0, n_tests = 0;
   always #10 sys_clk_i = ~sys_clk_i;
   bmc_config_regs i_bmc_config_regs (.sys_clk_i, .sys_rst_i, .cfg_wr_i,
      .cfg_rd_i, .cfg_addr_i, .cfg_be_i, .cfg_wdata_i, .cfg_rdata_o,
      .cfg_ack_o,
      .evt_rd_nodata_i(evt[0]), .evt_dw_nodeliver_i(evt[1]),
      .evt_tabort_pw_i(evt[2]), .evt_mabort_pw_i(evt[3]), .serr_cmd_en_i,
      .primary_system_error_out_n_o, .primary_system_error_oe_o, .gpio_i,
      .gpio_o, .gpio_oe_o, .gpio_level_o, .secondary_clock_outputs_en_o);
   bmc_cfg_host i_bmc_cfg_host (.sys_clk_i, .cfg_ack_i(cfg_ack_o),
      .cfg_rdata_i(cfg_rdata_o), .cfg_wr_o(cfg_wr_i), .cfg_rd_o(cfg_rd_i),
      .cfg_addr_o(cfg_addr_i), .cfg_be_o(cfg_be_i),
      .cfg_wdata_o(cfg_wdata_i));
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen,
                  exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [3:0] b,
                     input logic [31:0] d);
      i_bmc_cfg_host.acc(1'b1, a, b, d, q);
   endtask
   task automatic rd(input logic [7:0] a);
      i_bmc_cfg_host.acc(1'b0, a, 4'hF, 32'h0, q);
   endtask
   task automatic tally_and_finish;
      $display("errors %0d, checks %0d", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic do_reset;
      @(posedge sys_clk_i) sys_rst_i <= 1'b1;
      repeat (16) @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset_vals;
      check(gpio_o | gpio_oe_o, 0);
      check(secondary_clock_outputs_en_o, 10'h3FF);
      rd(8'h64);
      check(q, 0);
      rd(8'h68);
      check(q, 0);
   endtask
   task automatic t_gpio;
      wr(8'h64, 4'h2, 32'h1000);
      check(gpio_o, 1);
      check(gpio_oe_o, 0);
      wr(8'h64, 4'h4, 32'h100000);
      check({gpio_oe_o, gpio_o}, 8'h11);
      // Driven bit 0 now reads back through the pin filter
      repeat (5) @(posedge sys_clk_i);
      check(gpio_level_o, 4'hB);
      wr(8'h64, 4'h2, 32'h100);
      check(gpio_o, 0);
      wr(8'h64, 4'h4, 32'h10000);
      wr(8'h64, 4'hF, 32'h0);
      check({gpio_oe_o, gpio_o}, 0);
      rd(8'h64);
      check(q, 32'h00111100);
   endtask
   task automatic t_serr;
      int ev[7] = '{0, 0, 1, 2, 3, 1, 0};
      for (int b = 1; b < 7; b++) begin
         wr(8'h64, 4'h1, 32'h1 << b);
         @(posedge sys_clk_i) evt <= 4'h1 << ev[b];
         repeat (2) @(posedge sys_clk_i);
         check(primary_system_error_oe_o, 0);
         wr(8'h64, 4'h1, 32'h0);
         repeat (2) @(posedge sys_clk_i);
         check(primary_system_error_oe_o, 1);
         evt <= 4'h0;
      end
      @(posedge sys_clk_i) serr_cmd_en_i <= 1'b0;
      evt <= 4'hF;
      repeat (2) @(posedge sys_clk_i);
      check(primary_system_error_oe_o, 0);
      check(primary_system_error_out_n_o, 0);
      evt <= 4'h0;
      serr_cmd_en_i <= 1'b1;
   endtask
   task automatic t_clk;
      logic [15:0] v[4] = '{16'h0001, 16'h0003, 16'hFFFF, 16'h2AAA};
      foreach (v[k]) begin
         for (int j = 0; j < 10; j++) begin
            e[j] = (j < 4) ? !(v[k][2*j] && v[k][2*j+1]) : !v[k][j+4];
         end
         wr(8'h68, 4'h3, {16'h0, v[k]});
         @(posedge sys_clk_i);
         check(secondary_clock_outputs_en_o, e);
         rd(8'h68);
         check(q, v[k] & 16'h3FFF);
      end
   endtask
   task automatic t_regs;
      wr(8'h64, 4'hF, 32'hFFFFFFFF);
      wr(8'h70, 4'hF, 32'hFFFFFFFF);
      rd(8'h70);
      check(q, 0);
      rd(8'h64);
      check(q, 32'h00FFFF7E);
   endtask
   initial begin
      do_reset();
      t_reset_vals();
      t_gpio();
      t_serr();
      t_clk();
      t_regs();
      do_reset();
      t_reset_vals();
      tally_and_finish();
   end
   // Whole run needs well under a thousand cycles
   initial begin
      repeat (3000) @(posedge sys_clk_i);
      error_cnt++;
      tally_and_finish();
   end
endmodule
bind bmc_config_regs bmc_config_regs_checker #(.GPIO_W(GPIO_W), .CLK_N(CLK_N))
   i_bmc_config_regs_checker (.sys_clk_i, .sys_rst_i, .cfg_wr_i, .cfg_rd_i,
   .cfg_addr_i, .cfg_be_i, .cfg_wdata_i, .cfg_rdata_o, .cfg_ack_o,
   .evt_rd_nodata_i, .evt_dw_nodeliver_i, .evt_tabort_pw_i, .evt_mabort_pw_i,
   .serr_cmd_en_i, .primary_system_error_oe_o, .gpio_o, .gpio_oe_o,
   .secondary_clock_outputs_en_o);
